// ===== src/pplsd_defs.svh
`ifndef PPLSD_DEFS_SVH
`define PPLSD_DEFS_SVH

// Clock and blink timing
`define PPLSD_CLK_HZ          20000000
`define PPLSD_BLINK_HZ        4
`define PPLSD_BLINK_HALF_CYC  (`PPLSD_CLK_HZ / (2 * `PPLSD_BLINK_HZ))

// Register byte offsets
`define PPLSD_REG_CTRL        8'h00
`define PPLSD_REG_STATUS      8'h04
`define PPLSD_REG_GREEN       8'h08
`define PPLSD_REG_AMBER       8'h0C
`define PPLSD_REG_POE         8'h10

// Field positions and reset values
`define PPLSD_CTRL_EN_BIT     0
`define PPLSD_CTRL_RST        32'h0000_0001
`define PPLSD_STAT_BLINK_BIT  0

// Bus responses
`define PPLSD_RESP_OKAY       2'h0
`define PPLSD_RESP_SLVERR     2'h2

// Powered-device class bounds
`define PPLSD_BT_SS_MIN       4'h5
`define PPLSD_BT_SS_MAX       4'h8
`define PPLSD_BT_DS_MIN       4'h1
`define PPLSD_BT_DS_MAX       4'h5
`define PPLSD_AFAT_MAX        4'h4

`endif

// ===== src/pplsd_pkg.sv
package pplsd_pkg;

    // Negotiated link speed
    typedef enum logic [1:0] {
        SPD_10   = 2'h0,
        SPD_100  = 2'h1,
        SPD_1000 = 2'h2
    } pplsd_spd_e;

    // Standard the attached powered device follows
    typedef enum logic [1:0] {
        STD_NONE = 2'h0,
        STD_AFAT = 2'h1,
        STD_BT   = 2'h2
    } pplsd_std_e;

    // Physical flavour of a port
    typedef enum logic [1:0] {
        KIND_FAST  = 2'h0,
        KIND_GIG   = 2'h1,
        KIND_FIBER = 2'h2
    } pplsd_kind_e;

endpackage : pplsd_pkg

// ===== src/pplsd_port_enc.sv
`timescale 1ns/10ps
`include "pplsd_defs.svh"

module pplsd_port_enc (
    input  wire logic                  aclk,        // System clock
    input  wire logic                  aresetn,     // Synchronous reset, active low
    input  wire logic                  en,          // Indicators enabled
    input  wire logic                  blink,       // Shared 4 Hz phase
    input  wire pplsd_pkg::pplsd_kind_e kind,       // Port flavour
    input  wire logic                  link,        // Link up
    input  wire logic                  active,      // Port enabled
    input  wire pplsd_pkg::pplsd_spd_e speed,       // Link speed
    input  wire logic                  tx,          // Traffic activity
    input  wire logic                  pwr,         // Power delivered
    input  wire pplsd_pkg::pplsd_std_e pd_std,      // Device standard
    input  wire logic                  dual,        // Dual signature device
    input  wire logic [3:0]            pd_class,    // Device class
    input  wire logic                  det_fail,    // Detection failed
    input  wire logic                  overcur,     // Overcurrent
    input  wire logic                  budget_cut,  // Shut off for budget
    output logic                       green_q,     // Upper/green port LED
    output logic                       amber_q,     // Lower/amber port LED
    output logic                       poe_g_q,     // Green power LED
    output logic                       poe_a_q,     // Amber power LED
    output logic                       poe_r_q      // Red power LED
);

    logic green_d, amber_d, poe_g_d, poe_a_d, poe_r_d;
    logic up, g_sel, a_sel, lit, bt_ok, afat_ok;

    // Speed decode per flavour, traffic turns steady into blink
    always_comb begin
        up    = link && active;
        g_sel = 1'b0;
        a_sel = 1'b0;
        unique case (kind)
            pplsd_pkg::KIND_FAST: begin
                g_sel = (speed == pplsd_pkg::SPD_100);
                a_sel = (speed == pplsd_pkg::SPD_10);
            end
            pplsd_pkg::KIND_GIG: begin
                g_sel = (speed == pplsd_pkg::SPD_1000);
                a_sel = (speed == pplsd_pkg::SPD_10) || (speed == pplsd_pkg::SPD_100);
            end
            pplsd_pkg::KIND_FIBER: begin
                g_sel = (speed == pplsd_pkg::SPD_1000);
                a_sel = (speed == pplsd_pkg::SPD_100);
            end
            default: begin
                g_sel = 1'b0;
                a_sel = 1'b0;
            end
        endcase
        lit     = tx ? blink : 1'b1;
        green_d = en && up && g_sel && lit;
        amber_d = en && up && a_sel && lit;
        bt_ok   = pwr && (pd_std == pplsd_pkg::STD_BT) &&
                  (dual ? (pd_class >= `PPLSD_BT_DS_MIN && pd_class <= `PPLSD_BT_DS_MAX)
                        : (pd_class >= `PPLSD_BT_SS_MIN && pd_class <= `PPLSD_BT_SS_MAX));
        afat_ok = pwr && (pd_std == pplsd_pkg::STD_AFAT) && !dual &&
                  (pd_class <= `PPLSD_AFAT_MAX);
        poe_g_d = en && bt_ok;
        // Budget shutoff wins: the port is unpowered so steady amber cannot apply
        poe_a_d = en && (budget_cut ? blink : afat_ok);
        // Overcurrent is the more urgent fault, so its blink beats steady red
        poe_r_d = en && (overcur ? blink : det_fail);
    end

    // Register outputs so every LED comes from a flop and is dark in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            green_q <= 1'b0;
            amber_q <= 1'b0;
            poe_g_q <= 1'b0;
            poe_a_q <= 1'b0;
            poe_r_q <= 1'b0;
        end else begin
            green_q <= green_d;
            amber_q <= amber_d;
            poe_g_q <= poe_g_d;
            poe_a_q <= poe_a_d;
            poe_r_q <= poe_r_d;
        end
    end

    a_bt_single_on: assert property (@(posedge aclk) disable iff (!aresetn)
        en && pwr && pd_std == pplsd_pkg::STD_BT && !dual && pd_class >= 4'h5 &&
        pd_class <= 4'h8 |=> poe_g_q) else $error("green power LED not lit for bt class 5-8");
    a_bt_dual_on: assert property (@(posedge aclk) disable iff (!aresetn)
        en && pwr && pd_std == pplsd_pkg::STD_BT && dual && pd_class >= 4'h1 &&
        pd_class <= 4'h5 |=> poe_g_q) else $error("green power LED not lit for dual bt");
    a_green_pwr_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !pwr || pd_std != pplsd_pkg::STD_BT |=> !poe_g_q)
        else $error("green power LED lit without bt power");
    a_afat_amber_on: assert property (@(posedge aclk) disable iff (!aresetn)
        en && !budget_cut && pwr && pd_std == pplsd_pkg::STD_AFAT && !dual &&
        pd_class <= 4'h4 |=> poe_a_q) else $error("amber power LED not lit for af/at");
    a_budget_blink: assert property (@(posedge aclk) disable iff (!aresetn)
        en && budget_cut |=> poe_a_q == $past(blink))
        else $error("amber power LED not following blink on budget cut");
    a_amber_pwr_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !budget_cut && (!pwr || pd_std != pplsd_pkg::STD_AFAT) |=> !poe_a_q)
        else $error("amber power LED lit without af/at power");
    a_red_detect: assert property (@(posedge aclk) disable iff (!aresetn)
        en && det_fail && !overcur |=> poe_r_q) else $error("red LED not lit on detect fail");
    a_red_overcur: assert property (@(posedge aclk) disable iff (!aresetn)
        en && overcur |=> poe_r_q == $past(blink))
        else $error("red LED not blinking on overcurrent");
    a_red_normal: assert property (@(posedge aclk) disable iff (!aresetn)
        !det_fail && !overcur |=> !poe_r_q) else $error("red LED lit in normal operation");
    a_speed_green: assert property (@(posedge aclk) disable iff (!aresetn)
        en && link && active && !tx &&
        ((kind == pplsd_pkg::KIND_FAST && speed == pplsd_pkg::SPD_100) ||
         (kind != pplsd_pkg::KIND_FAST && speed == pplsd_pkg::SPD_1000))
        |=> green_q && !amber_q) else $error("wrong port LED for speed");
    a_tx_blink: assert property (@(posedge aclk) disable iff (!aresetn)
        en && link && active && tx && kind == pplsd_pkg::KIND_GIG &&
        speed == pplsd_pkg::SPD_10 |=> amber_q == $past(blink) && !green_q)
        else $error("speed LED not blinking with traffic");
    a_link_dark: assert property (@(posedge aclk) disable iff (!aresetn)
        !link || !active |=> !green_q && !amber_q) else $error("port LED lit with link down");

endmodule : pplsd_port_enc

// ===== src/pplsd_top.sv
// Function
// - Green power LED steady for single-signature bt device class 5 to 8 powered.
// - Green power LED steady for dual-signature bt device class 1 to 5 powered.
// - Green power LED dark without power or without a bt device.
// - Amber power LED steady for af/at single-signature device class 0 to 4.
// - Amber power LED blinks 4 Hz when power is cut for low budget.
// - Amber power LED dark without power or without an af/at device, unless power is cut for budget.
// - Red power LED steady while powered-device detection has failed.
// - Red power LED blinks 4 Hz while overcurrent is reported.
// - Red power LED dark while power delivery is normal.
// - Fast copper port: green at 100 Mb/s, amber at 10 Mb/s.
// - Gigabit copper port: green at 1000, amber at 10 or 100 Mb/s.
// - Fibre port: green at 1000 Mb/s, amber at 100 Mb/s.
// - Speed LED blinks 4 Hz instead of steady while traffic flows.
// - Both port LEDs dark when port inactive or link down.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pplsd_defs.svh"

module pplsd_top #(
    parameter int unsigned NPORT          = 12,                     // Switch ports
    parameter int unsigned NFAST          = 8,                      // Leading 10/100 ports
    parameter int unsigned NPOE           = 8,                      // Leading PoE ports
    parameter int unsigned BLINK_HALF_CYC = `PPLSD_BLINK_HALF_CYC   // Cycles per blink half
) (
    input  wire logic                 aclk,           // System clock, 20 MHz
    input  wire logic                 aresetn,        // Synchronous reset, active low
    input  wire logic [7:0]           s_awaddr,       // Write address
    input  wire logic                 s_awvalid,      // Write address valid
    output logic                      s_awready,      // Write address ready
    input  wire logic [31:0]          s_wdata,        // Write data
    input  wire logic [3:0]           s_wstrb,        // Write byte strobes
    input  wire logic                 s_wvalid,       // Write data valid
    output logic                      s_wready,       // Write data ready
    output logic [1:0]                s_bresp,        // Write response
    output logic                      s_bvalid,       // Write response valid
    input  wire logic                 s_bready,       // Write response ready
    input  wire logic [7:0]           s_araddr,       // Read address
    input  wire logic                 s_arvalid,      // Read address valid
    output logic                      s_arready,      // Read address ready
    output logic [31:0]               s_rdata,        // Read data
    output logic [1:0]                s_rresp,        // Read response
    output logic                      s_rvalid,       // Read data valid
    input  wire logic                 s_rready,       // Read data ready
    input  wire logic [NPORT-1:0]     port_active,    // Port enabled
    input  wire logic [NPORT-1:0]     port_link,      // Link up
    input  wire logic [2*NPORT-1:0]   port_speed,     // Speed code per port
    input  wire logic [NPORT-1:0]     port_tx,        // Traffic activity
    input  wire logic [NPORT-1:0]     port_fiber,     // Combo port uses fibre module
    input  wire logic [NPOE-1:0]      poe_power,      // Power delivered
    input  wire logic [2*NPOE-1:0]    poe_std,        // Device standard code
    input  wire logic [NPOE-1:0]      poe_dual,       // Dual signature device
    input  wire logic [4*NPOE-1:0]    poe_class,      // Device class
    input  wire logic [NPOE-1:0]      poe_det_fail,   // Detection failed
    input  wire logic [NPOE-1:0]      poe_overcur,    // Overcurrent
    input  wire logic [NPOE-1:0]      poe_budget_cut, // Shut off for budget
    output logic [NPORT-1:0]          led_green,      // Upper/green port LEDs
    output logic [NPORT-1:0]          led_amber,      // Lower/amber port LEDs
    output logic [NPOE-1:0]           led_poe_green,  // Green power LEDs
    output logic [NPOE-1:0]           led_poe_amber,  // Amber power LEDs
    output logic [NPOE-1:0]           led_poe_red     // Red power LEDs
);

    localparam int unsigned CW = $clog2(BLINK_HALF_CYC);

    logic [CW-1:0] cnt_q, cnt_d;
    logic          blink_q, blink_d;
    logic          en_q, en_d;

    // Shared divider; a single phase keeps every blinking LED in step
    always_comb begin
        cnt_d   = cnt_q + CW'(1);
        blink_d = blink_q;
        if (cnt_q == CW'(BLINK_HALF_CYC - 1)) begin
            cnt_d   = '0;
            blink_d = !blink_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q   <= '0;
            blink_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            blink_q <= blink_d;
        end
    end

    // Bus slave state
    logic       aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic       awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;

    // Padded per-port views so one encoder serves every port
    logic [NPORT-1:0]   g_all, a_all, pg_all, pa_all, pr_all;
    logic [NPORT-1:0]   pwr_x, dual_x, det_x, oc_x, bud_x;
    logic [2*NPORT-1:0] std_x;
    logic [4*NPORT-1:0] cls_x;

    // Write takes address and data in either order, read is one deep
    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = s_bvalid;
        bresp_d   = s_bresp;
        en_d      = en_q;
        rvalid_d  = s_rvalid;
        rresp_d   = s_rresp;
        rdata_d   = s_rdata;
        if (s_awvalid && s_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_hold_d = 1'b1;
            wdata_d  = s_wdata;
            wstrb_d  = s_wstrb;
        end
        if (s_bvalid && s_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_hold_d && w_hold_d && !s_bvalid) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `PPLSD_RESP_OKAY;
            if (awaddr_d[7:2] == 6'(`PPLSD_REG_CTRL >> 2)) begin
                if (wstrb_d[0]) begin
                    en_d = wdata_d[`PPLSD_CTRL_EN_BIT];
                end
            end else if (awaddr_d[7:2] > 6'(`PPLSD_REG_POE >> 2)) begin
                bresp_d = `PPLSD_RESP_SLVERR;
            end
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d  = !w_hold_d && !bvalid_d;
        if (s_rvalid && s_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = `PPLSD_RESP_OKAY;
            rdata_d  = '0;
            unique case (s_araddr[7:2])
                6'(`PPLSD_REG_CTRL >> 2):   rdata_d[`PPLSD_CTRL_EN_BIT] = en_q;
                6'(`PPLSD_REG_STATUS >> 2): rdata_d[`PPLSD_STAT_BLINK_BIT] = blink_q;
                6'(`PPLSD_REG_GREEN >> 2):  rdata_d[NPORT-1:0] = led_green;
                6'(`PPLSD_REG_AMBER >> 2):  rdata_d[NPORT-1:0] = led_amber;
                6'(`PPLSD_REG_POE >> 2):    rdata_d[3*NPOE-1:0] =
                                                {led_poe_red, led_poe_amber, led_poe_green};
                default:                    rresp_d = `PPLSD_RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= `PPLSD_RESP_OKAY;
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rresp   <= `PPLSD_RESP_OKAY;
            s_rdata   <= '0;
            en_q      <= 1'(`PPLSD_CTRL_RST);
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            s_awready <= awready_d;
            s_wready  <= wready_d;
            s_bvalid  <= bvalid_d;
            s_bresp   <= bresp_d;
            s_arready <= arready_d;
            s_rvalid  <= rvalid_d;
            s_rresp   <= rresp_d;
            s_rdata   <= rdata_d;
            en_q      <= en_d;
        end
    end

    // Ports beyond the PoE range see no power activity
    assign pwr_x  = {{(NPORT-NPOE){1'b0}}, poe_power};
    assign dual_x = {{(NPORT-NPOE){1'b0}}, poe_dual};
    assign det_x  = {{(NPORT-NPOE){1'b0}}, poe_det_fail};
    assign oc_x   = {{(NPORT-NPOE){1'b0}}, poe_overcur};
    assign bud_x  = {{(NPORT-NPOE){1'b0}}, poe_budget_cut};
    assign std_x  = {{(2*(NPORT-NPOE)){1'b0}}, poe_std};
    assign cls_x  = {{(4*(NPORT-NPOE)){1'b0}}, poe_class};

    // One encoder per port; flavour follows position and the fibre select
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        pplsd_port_enc u_enc (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .en         (en_q),
            .blink      (blink_q),
            .kind       (i < NFAST ? pplsd_pkg::KIND_FAST :
                         (port_fiber[i] ? pplsd_pkg::KIND_FIBER : pplsd_pkg::KIND_GIG)),
            .link       (port_link[i]),
            .active     (port_active[i]),
            .speed      (pplsd_pkg::pplsd_spd_e'(port_speed[2*i +: 2])),
            .tx         (port_tx[i]),
            .pwr        (pwr_x[i]),
            .pd_std     (pplsd_pkg::pplsd_std_e'(std_x[2*i +: 2])),
            .dual       (dual_x[i]),
            .pd_class   (cls_x[4*i +: 4]),
            .det_fail   (det_x[i]),
            .overcur    (oc_x[i]),
            .budget_cut (bud_x[i]),
            .green_q    (g_all[i]),
            .amber_q    (a_all[i]),
            .poe_g_q    (pg_all[i]),
            .poe_a_q    (pa_all[i]),
            .poe_r_q    (pr_all[i])
        );
    end

    // Outputs are the encoder flops themselves
    assign led_green     = g_all;
    assign led_amber     = a_all;
    assign led_poe_green = pg_all[NPOE-1:0];
    assign led_poe_amber = pa_all[NPOE-1:0];
    assign led_poe_red   = pr_all[NPOE-1:0];

    a_blink_period: assert property (@(posedge aclk) disable iff (!aresetn)
        blink_q != $past(blink_q) |-> $past(cnt_q) == CW'(BLINK_HALF_CYC - 1))
        else $error("blink phase changed off the divider wrap");
    a_blink_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        cnt_q == CW'(BLINK_HALF_CYC - 1) |=> blink_q != $past(blink_q) && cnt_q == '0)
        else $error("blink phase did not toggle at wrap");
    a_reset_dark: assert property (@(posedge aclk)
        !aresetn |=> led_green == '0 && led_amber == '0 && led_poe_green == '0 &&
        led_poe_amber == '0 && led_poe_red == '0) else $error("LED lit after reset edge");

endmodule : pplsd_top

// ===== dv/pplsd_led_panel.sv
`timescale 1ns/10ps

module pplsd_led_panel (
    input  wire logic        aclk,         // System clock
    input  wire logic        clr,          // Clear lit-time counters
    input  wire logic [47:0] lamps,        // All front-panel lamps, high = lit
    output int               on_cnt [48]   // Cycles each lamp was lit
);
    // A lamp has no memory; counting lit cycles lets the bench judge blink duty
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 48; k++) begin
            on_cnt[k] <= clr ? 0 : on_cnt[k] + int'(lamps[k]);
        end
    end
endmodule : pplsd_led_panel

// ===== dv/pplsd_top_tb_top.sv
`timescale 1ns/10ps

module pplsd_top_tb_top;
    logic aclk = 0, aresetn = 0, clr = 0;
    logic [7:0] s_awaddr = 0, s_araddr = 0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic [31:0] s_wdata = 0, s_rdata, rd;
    logic [3:0] s_wstrb = 4'hF;
    logic [1:0] s_bresp, s_rresp, rr;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [11:0] port_active = '1, port_link = '1, port_tx = 0, port_fiber = 0;
    logic [23:0] port_speed = 0;
    logic [7:0] poe_power = 0, poe_dual = 0, poe_det_fail = 0, poe_overcur = 0;
    logic [7:0] poe_budget_cut = 0;
    logic [15:0] poe_std = 0;
    logic [31:0] poe_class = 0;
    logic [11:0] led_green, led_amber;
    logic [7:0] led_poe_green, led_poe_amber, led_poe_red;
    int on_cnt [48];
    int mismatches = 0, n_compared = 0;

    always #25 aclk = ~aclk;  // 20 MHz

    pplsd_top #(.BLINK_HALF_CYC(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .port_active(port_active), .port_link(port_link), .port_speed(port_speed),
        .port_tx(port_tx), .port_fiber(port_fiber), .poe_power(poe_power),
        .poe_std(poe_std), .poe_dual(poe_dual), .poe_class(poe_class),
        .poe_det_fail(poe_det_fail), .poe_overcur(poe_overcur),
        .poe_budget_cut(poe_budget_cut), .led_green(led_green), .led_amber(led_amber),
        .led_poe_green(led_poe_green), .led_poe_amber(led_poe_amber),
        .led_poe_red(led_poe_red));

    pplsd_led_panel u_panel (.aclk(aclk), .clr(clr), .on_cnt(on_cnt),
        .lamps({led_poe_red, led_poe_amber, led_poe_green, led_amber, led_green}));

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Bus master: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, input logic [1:0] er);
        bit aw = 0;
        bit w = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= s;
        s_awvalid <= 1;
        s_wvalid <= 1;
        s_bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_awvalid && s_awready) begin
                aw = 1;
                s_awvalid <= 0;
            end
            if (s_wvalid && s_wready) begin
                w = 1;
                s_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        s_bready <= 0;
        chk(s_bresp, er);
    endtask : axi_write

    // Requests start on an edge so the slave never sees a mid-cycle change
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1;
        s_rready <= 1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 0;
        while (s_rvalid !== 1'b1) @(posedge aclk);
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 0;
    endtask : axi_read

    // Reference: lit cycles in a 16-cycle window, 16 steady, 8 blinking, 0 dark
    task automatic check_all(input bit en);
        int exp [48];
        int sp, m, c;
        @(posedge aclk); clr <= 1;
        @(posedge aclk); clr <= 0;
        repeat (16) @(posedge aclk);
        #1;
        for (int i = 0; i < 12; i++) begin
            sp = port_speed[2*i+:2];
            m = !(en && port_active[i] && port_link[i]) ? 0 : port_tx[i] ? 8 : 16;
            exp[i] = ((i < 8) ? sp == 1 : sp == 2) ? m : 0;
            exp[12+i] = ((i < 8) ? sp == 0 : port_fiber[i] ? sp == 1 : sp < 2) ? m : 0;
        end
        for (int j = 0; j < 8; j++) begin
            sp = poe_std[2*j+:2];
            c = poe_class[4*j+:4];
            exp[24+j] = (en && poe_power[j] && sp == 2 &&
                (poe_dual[j] ? (c >= 1 && c <= 5) : (c >= 5 && c <= 8))) ? 16 : 0;
            exp[32+j] = !en ? 0 : poe_budget_cut[j] ? 8 :
                (poe_power[j] && sp == 1 && !poe_dual[j] && c <= 4) ? 16 : 0;
            exp[40+j] = !en ? 0 : poe_overcur[j] ? 8 : poe_det_fail[j] ? 16 : 0;
        end
        for (int k = 0; k < 48; k++) chk(on_cnt[k], exp[k]);
    endtask : check_all

    task automatic randomize_inputs();
        @(posedge aclk);
        for (int i = 0; i < 12; i++) begin
            port_active[i] <= ($urandom % 5) != 0;
            port_link[i] <= ($urandom % 5) != 0;
            port_tx[i] <= $urandom % 2;
            port_fiber[i] <= $urandom % 2;
            // Every code, the unused one and 1000 Mb/s on a fast port included
            port_speed[2*i+:2] <= $urandom % 4;
        end
        for (int j = 0; j < 8; j++) begin
            poe_power[j] <= ($urandom % 4) != 0;
            poe_std[2*j+:2] <= $urandom % 3;
            poe_dual[j] <= $urandom % 2;
            poe_class[4*j+:4] <= $urandom % 10;
            poe_det_fail[j] <= ($urandom % 4) == 0;
            poe_overcur[j] <= ($urandom % 4) == 0;
            poe_budget_cut[j] <= ($urandom % 4) == 0;
        end
        @(posedge aclk);
        // Fibre at 10 Mb/s is not a legal link; move fibre ports at 10 up to 100
        for (int i = 8; i < 12; i++) if (port_fiber[i] && port_speed[2*i+:2] == 0)
            port_speed[2*i+:2] <= 2'h1;
    endtask : randomize_inputs

    // Watchdog sized well above the roughly one thousand cycles the tests need
    initial begin
        #(50 * 20000);
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h993b));
        repeat (6) @(posedge aclk);
        #1 chk({led_poe_red, led_poe_amber, led_poe_green, led_amber, led_green}, 0);
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1 chk(led_amber, 12'hFFF);
        axi_read(8'h00);
        chk(rd, 32'h1);
        // All links up at 10 Mb/s with no traffic: every amber steady, nothing else
        axi_read(8'h0C);
        chk(rd, 32'hFFF);
        axi_read(8'h08);
        chk(rd, 32'h0);
        axi_read(8'h10);
        chk(rd, 32'h0);
        axi_read(8'h14);
        chk(rr, 2'h2);
        chk(rd, 32'h0);
        for (int n = 0; n < 40; n++) begin
            randomize_inputs();
            check_all(1);
        end
        // Disabled indicators go dark whatever the status inputs say
        axi_write(8'h00, 32'h0, 4'hF, 2'h0);
        check_all(0);
        axi_write(8'h00, 32'h1, 4'hF, 2'h0);
        check_all(1);
        // Upper strobes alone leave the enable set; an unmapped offset answers an error
        axi_write(8'h00, 32'h0, 4'hE, 2'h0);
        axi_write(8'h14, 32'h0, 4'hF, 2'h2);
        axi_read(8'h00);
        chk(rd, 32'h1);
        check_all(1);
        give_verdict();
    end
endmodule : pplsd_top_tb_top
